//--- core/adc_seq_params.svh
// Offsets, field positions and fixed counts of the converter sequencer.
// Assumes 8-bit byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH
// ==========================================================
// Register offsets
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_SCAN_LOW 8'h08
`define OFS_SCAN_HIGH 8'h0c
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_POSITION 8'h18
`define OFS_SLOT_BASE 8'h40
`define OFS_SLOT_END 8'h80
// ==========================================================
// Field positions
`define C1_DONE_BIT 0
`define C1_SAMPLE_BIT 1
`define C1_ENABLE_BIT 15
`define C2_SPI_LSB 0
`define C2_DMA_BIT 8
`define C2_SCAN_BIT 10
`define C2_CHAN_LSB 16
`define IRQ_SPI_BIT 0
`define IRQ_DMA_BIT 1
`define POS_SLOT_LSB 0
`define POS_CNT_LSB 8
`define POS_CHAN_LSB 16
`define POS_DMA_LSB 24
// ==========================================================
// Counts and answers
`define SLOT_COUNT 16
`define DMA_INC_EVERY 32
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RST_READY 1'b1
`endif

//--- core/adc_seq_pkg.sv
// Types shared by the converter sequencer and its result memory.
// Assumes the constants header is on the include path.
package adc_seq_pkg;
`include "adc_seq_params.svh"
  typedef logic [15:0] sample_t;
  typedef logic [3:0] slot_t;
  typedef logic [4:0] chan_t;
  typedef logic [4:0] count_t;

  typedef struct packed {
    logic [`SLOT_COUNT-1:0][15:0] slot;
    sample_t rd_data;
  } mem_state_t;

  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [7:0] awaddr;
    logic wready;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic ar_pend;
    logic [7:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic enable;
    logic sample_start_bit;
    logic done;
    count_t spi;
    logic dma_en;
    logic scan_en;
    chan_t chan_fix;
    logic [15:0] scan_low;
    logic [15:0] scan_high;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    count_t cnt;
    slot_t slot;
    chan_t chan;
    count_t dma_cnt;
    logic dma_inc;
  } seq_state_t;
endpackage

//--- core/result_if.sv
// Write and read port pair between the sequencer and its result slots.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface result_if;
  import adc_seq_pkg::*;
  logic wr_en;
  slot_t wr_slot;
  sample_t wr_data;
  slot_t rd_slot;
  sample_t rd_data;
  modport ctl (output wr_en, output wr_slot, output wr_data, output rd_slot, input rd_data);
  modport mem (input wr_en, input wr_slot, input wr_data, input rd_slot, output rd_data);
endinterface

//--- core/result_mem.sv
// Sixteen result slots with one write port and one registered read port.
// Assumes the read slot is presented one cycle before its data is used.
`timescale 1ns/1ps
module result_mem
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  result_if.mem port
);
  mem_state_t st_ff;
  mem_state_t nxt_st;

  // ==========================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    if (port.wr_en)
    begin
      nxt_st.slot[port.wr_slot] = port.wr_data;
    end
    // A read in the cycle of a write to the same slot returns the old value.
    nxt_st.rd_data = st_ff.slot[port.rd_slot];
  end

  assign port.rd_data = st_ff.rd_data;

  // ==========================================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end
endmodule

//--- core/adc_result_buffer_sequencer.sv
// Converter sequencer: conversion counting, scan restart, result slots, DMA pacing.
// Assumes conv_start and conv_end are one-cycle pulses synchronous to aclk.
//
// Overview of operation
// [R1] Interrupt flag set when per-interrupt count completes.
// [R2] Scan list restarts after count when scanning.
// [R3] Slot pointer resets after count without DMA.
// [R4] DMA mode writes every result to slot zero.
// [R5] DMA address advances every thirty-second conversion.
// [R6] Sixteen slots filled in sequential order.
// [R7] Slot chosen by pointer, never by channel.
// [R8] Reader drains slot zero before next conversion.
// [R9] Done cleared at conversion start, set at end.
// [R10] Software clears done just before manual sample.
// [R11] Disabling resets counter, slot pointer, scan position.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "adc_seq_params.svh"
module adc_result_buffer_sequencer
  import adc_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_start,
  input wire logic conv_end,
  input wire logic [15:0] conv_result,
  output logic sample_request,
  output logic [4:0] scan_channel,
  output logic dma_addr_inc,
  output logic done_flag,
  output logic irq
);
  seq_state_t st_ff;
  seq_state_t nxt_st;
  result_if res ();

  result_mem u_mem
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .port(res.mem)
  );

  // ==========================================================
  // Helpers

  // Next selected scan channel at or above from, wrapping round the list.
  function automatic chan_t first_set(input logic [31:0] mask, input chan_t from);
    chan_t r;
    chan_t idx;
    logic hit;
    r = '0;
    hit = 1'b0;
    for (int k = 0; k < 32; k++)
    begin
      idx = from + chan_t'(k);
      if (!hit && mask[idx])
      begin
        r = idx;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // True for a byte address inside the result slot window.
  function automatic logic in_slot_window(input logic [7:0] a);
    return (a >= `OFS_SLOT_BASE) && (a < `OFS_SLOT_END);
  endfunction

  // Read image of a control or status register; bit 32 flags a mapped address.
  function automatic logic [32:0] reg_image(input seq_state_t s, input logic [7:0] a);
    logic [31:0] v;
    logic hit;
    v = '0;
    hit = 1'b1;
    case (a)
      `OFS_CTRL_ONE:
      begin
        v[`C1_ENABLE_BIT] = s.enable;
        v[`C1_SAMPLE_BIT] = s.sample_start_bit;
        v[`C1_DONE_BIT] = s.done;
      end
      `OFS_CTRL_TWO:
      begin
        v[`C2_SPI_LSB +: 5] = s.spi;
        v[`C2_DMA_BIT] = s.dma_en;
        v[`C2_SCAN_BIT] = s.scan_en;
        v[`C2_CHAN_LSB +: 5] = s.chan_fix;
      end
      `OFS_SCAN_LOW: v[15:0] = s.scan_low;
      `OFS_SCAN_HIGH: v[15:0] = s.scan_high;
      `OFS_IRQ_STATUS: v[1:0] = s.irq_status;
      `OFS_IRQ_MASK: v[1:0] = s.irq_mask;
      `OFS_POSITION:
      begin
        v[`POS_SLOT_LSB +: 4] = s.slot;
        v[`POS_CNT_LSB +: 5] = s.cnt;
        v[`POS_CHAN_LSB +: 5] = s.chan;
        v[`POS_DMA_LSB +: 5] = s.dma_cnt;
      end
      default: hit = 1'b0;
    endcase
    return {hit, v};
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [32:0] img;
    logic [31:0] m;
    logic [31:0] scan_mask;
    logic wrap;
    img = '0;
    m = '0;
    scan_mask = '0;
    wrap = 1'b0;
    nxt_st = st_ff;
    nxt_st.dma_inc = 1'b0;
    res.wr_en = 1'b0;
    res.wr_slot = '0;
    res.wr_data = conv_result;
    res.rd_slot = s_axi_araddr[5:2];

    // Bus write: address and data are taken independently, then applied together.
    if (s_axi_awvalid && st_ff.awready)
    begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready)
    begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready)
    begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
    begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `RESP_OKAY;
      img = reg_image(st_ff, st_ff.awaddr);
      m = merge(img[31:0], st_ff.wdata, st_ff.wstrb);
      case (st_ff.awaddr)
        `OFS_CTRL_ONE:
        begin
          nxt_st.enable = m[`C1_ENABLE_BIT];
          nxt_st.sample_start_bit = m[`C1_SAMPLE_BIT];
          nxt_st.done = m[`C1_DONE_BIT]; // [R10]
        end
        `OFS_CTRL_TWO:
        begin
          nxt_st.spi = m[`C2_SPI_LSB +: 5];
          nxt_st.dma_en = m[`C2_DMA_BIT];
          nxt_st.scan_en = m[`C2_SCAN_BIT];
          nxt_st.chan_fix = m[`C2_CHAN_LSB +: 5];
        end
        `OFS_SCAN_LOW: nxt_st.scan_low = m[15:0];
        `OFS_SCAN_HIGH: nxt_st.scan_high = m[15:0];
        `OFS_IRQ_STATUS:
        begin
          m = merge(32'h0000_0000, st_ff.wdata, st_ff.wstrb);
          nxt_st.irq_status = st_ff.irq_status & ~m[1:0];
        end
        `OFS_IRQ_MASK: nxt_st.irq_mask = m[1:0];
        `OFS_POSITION:
        begin
          // Read-only view of the sequencer position; writes are ignored.
        end
        default: nxt_st.bresp = `RESP_SLVERR;
      endcase
    end

    // Bus read: the slot memory answers one cycle after the address is taken.
    // The slot memory reads its address straight off the bus at the take edge, so the
    // registered word is already waiting when the answer is built one edge later.
    if (st_ff.rvalid && s_axi_rready)
    begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready)
    begin
      nxt_st.ar_pend = 1'b1;
      nxt_st.araddr = s_axi_araddr;
    end
    if (st_ff.ar_pend)
    begin
      nxt_st.ar_pend = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `RESP_OKAY;
      img = reg_image(st_ff, st_ff.araddr);
      nxt_st.rdata = img[31:0];
      if (in_slot_window(st_ff.araddr))
      begin
        nxt_st.rdata = {16'h0000, res.rd_data};
      end
      else if (!img[32])
      begin
        nxt_st.rresp = `RESP_SLVERR;
      end
    end

    // Conversion sequencing.
    scan_mask = {nxt_st.scan_high, nxt_st.scan_low};
    wrap = (st_ff.cnt == st_ff.spi);
    // Disabling also drops a pending manual sample, so that enabling again never
    // starts a stale sample left over from before.
    if (!nxt_st.enable)
    begin
      nxt_st.cnt = '0; // [R11]
      nxt_st.slot = '0; // [R11]
      nxt_st.dma_cnt = '0;
      nxt_st.chan = first_set(scan_mask, 5'h00); // [R11]
      nxt_st.sample_start_bit = 1'b0;
    end
    else
    begin
      if (conv_start)
      begin
        nxt_st.done = 1'b0; // [R9]
        nxt_st.sample_start_bit = 1'b0;
      end
      if (conv_end)
      begin
        // The done flag stays set through the next sample phase.
        nxt_st.done = 1'b1; // [R9]
        res.wr_en = 1'b1;
        // In DMA mode slot zero is overwritten by each result; the reader must keep pace.
        res.wr_slot = st_ff.dma_en ? slot_t'(0) : st_ff.slot; // [R4] [R7] [R8]
        // The pacing counter runs from enable, independent of the per-interrupt count.
        if (st_ff.dma_en)
        begin
          nxt_st.dma_cnt = st_ff.dma_cnt + 5'h01;
          if (st_ff.dma_cnt == count_t'(`DMA_INC_EVERY - 1))
          begin
            nxt_st.dma_inc = 1'b1; // [R5]
            nxt_st.irq_status[`IRQ_DMA_BIT] = 1'b1;
          end
        end
        // Both pointers restart together, so the next block of results begins at
        // slot zero and, with scanning on, at the first channel of the scan list.
        if (wrap)
        begin
          nxt_st.cnt = '0;
          nxt_st.slot = '0; // [R3]
          nxt_st.irq_status[`IRQ_SPI_BIT] = 1'b1; // [R1]
          nxt_st.chan = first_set(scan_mask, 5'h00); // [R2]
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt + 5'h01;
          nxt_st.slot = st_ff.dma_en ? slot_t'(0) : st_ff.slot + 4'h1; // [R6]
          nxt_st.chan = first_set(scan_mask, st_ff.chan + 5'h01);
        end
      end
      if (!nxt_st.scan_en)
      begin
        nxt_st.chan = nxt_st.chan_fix;
      end
    end

    nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
    // Readies come from the next state so no channel is offered while its answer is
    // pending; this costs two idle cycles between two writes or two reads.
    nxt_st.awready = !nxt_st.aw_held && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_held && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.ar_pend && !nxt_st.rvalid;
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= '0;
      // The readies leave reset high, so the first request is taken without a
      // wasted cycle.
      st_ff.awready <= `RST_READY;
      st_ff.wready <= `RST_READY;
      st_ff.arready <= `RST_READY;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign sample_request = st_ff.sample_start_bit;
  assign scan_channel = st_ff.chan;
  assign dma_addr_inc = st_ff.dma_inc;
  assign done_flag = st_ff.done;
  assign irq = st_ff.irq;
endmodule

//--- test/adc_seq_sva.sv
// Checker for the sequencer's bus handshakes and converter outputs.
// Assumes ce is held high, as the bench does.
`timescale 1ns/1ps
module adc_seq_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic conv_end,
  input wire logic dma_addr_inc,
  input wire logic done_flag,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Register bus
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  b_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  // ==========================================
  // Converter side
  dma_cause_a: assert property (dma_addr_inc |-> $past(conv_end))
    else $error("dma advance without conversion");
  dma_pulse_a: assert property (dma_addr_inc |=> !dma_addr_inc [*8])
    else $error("dma advance too often");
  done_cause_a: assert property ($rose(done_flag) |-> $past(conv_end))
    else $error("done set without conversion");
  cover property (dma_addr_inc);
  cover property ($rose(irq));
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule
bind adc_result_buffer_sequencer adc_seq_sva i_adc_seq_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .conv_end(conv_end), .dma_addr_inc(dma_addr_inc), .done_flag(done_flag), .irq(irq));

//--- test/dma_model.sv
// Stand-in for the DMA controller: follows address advance pulses.
// Assumes one-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
module dma_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dma_addr_inc,
  output logic [7:0] dma_addr_ff
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_addr_ff <= 8'h00;
    else if (dma_addr_inc)
      dma_addr_ff <= dma_addr_ff + 8'h01;
  end
endmodule

//--- test/test_adc_result_buffer_sequencer.sv
// Self-checking bench for the converter sequencer.
// Assumes one 200 MHz clock and ce held high.
`timescale 1ns/1ps
module test_adc_result_buffer_sequencer;
  import adc_seq_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, conv_start, conv_end;
  logic awready, wready, bvalid, arready, rvalid, sample_request, dma_addr_inc, done_flag, irq;
  logic [7:0] awaddr, araddr, dma_addr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [4:0] scan_channel;
  logic [15:0] conv_result, m, v;
  logic [15:0] slots [16];
  int n_errors, n_compared, n;
  adc_result_buffer_sequencer i_adc_result_buffer_sequencer (.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv_start(conv_start), .conv_end(conv_end),
    .conv_result(conv_result), .sample_request(sample_request), .scan_channel(scan_channel),
    .dma_addr_inc(dma_addr_inc), .done_flag(done_flag), .irq(irq));
  dma_model i_dma_model (.aclk(aclk), .aresetn(aresetn), .dma_addr_inc(dma_addr_inc),
    .dma_addr_ff(dma_addr));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Start pulse, then end pulse with the result; done is checked after each.
  task conv(input logic [15:0] x);
    @(posedge aclk);
    conv_start <= 1'b1;
    @(posedge aclk);
    conv_start <= 1'b0;
    conv_end <= 1'b1;
    conv_result <= x;
    #1 chk("done_flag", 32'(done_flag), 32'h0);
    @(posedge aclk);
    conv_end <= 1'b0;
    #1 chk("done_flag", 32'(done_flag), 32'h1);
  endtask
  function automatic logic [4:0] first_ch(input logic [15:0] s);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 15; i >= 0; i--)
      if (s[i])
        c = 5'(i);
    return c;
  endfunction
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    finish_test;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, conv_start, conv_end} = 8'h00;
    {awaddr, araddr, wdata, conv_result} = '0;
    foreach (slots[i])
      slots[i] = 16'h0000;
    n = $urandom(44227);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h20);
    chk("unmapped rresp", 32'(r), 32'h2);
    chk("unmapped rdata", d, 32'h0);
    wr(8'h40, 32'h1, 2'b10);
    m = 16'($urandom) | 16'h8000;
    n = $urandom_range(1, 16);
    wr(8'h08, {16'h0000, m}, 2'b00);
    wr(8'h14, 32'h1, 2'b00);
    wr(8'h04, 32'h400 | 32'(n - 1), 2'b00);
    wr(8'h00, 32'h8000, 2'b00);
    for (int rep = 0; rep < 2; rep++)
    begin
      for (int i = 0; i < n; i++)
      begin
        v = 16'($urandom);
        conv(v);
        slots[i] = v;
        chk("irq", 32'(irq), 32'(i == n - 1 && rep == 0));
      end
      chk("scan_channel", 32'(scan_channel), 32'(first_ch(m)));
      rd(8'h18);
      chk("slot pointer", 32'(d[3:0]), 32'h0);
      rd(8'h10);
      chk("count status", 32'(d[0]), 32'h1);
      for (int i = 0; i < n; i++)
      begin
        rd(8'(8'h40 + 4 * i));
        chk("slot", 32'(d[15:0]), 32'(slots[i]));
      end
      wr(8'h10, 32'h1, 2'b00);
      chk("irq", 32'(irq), 32'h0);
      wr(8'h14, 32'h0, 2'b00);
    end
    wr(8'h00, 32'h8000, 2'b00);
    chk("done_flag", 32'(done_flag), 32'h0);
    wr(8'h00, 32'h8002, 2'b00);
    chk("sample_request", 32'(sample_request), 32'h1);
    conv(16'h1234);
    chk("sample_request", 32'(sample_request), 32'h0);
    wr(8'h00, 32'h0, 2'b00);
    rd(8'h18);
    chk("position", 32'({d[12:8], d[3:0]}), 32'h0);
    wr(8'h04, 32'h0007_0100, 2'b00);
    wr(8'h00, 32'h8000, 2'b00);
    for (int i = 0; i < 32; i++)
    begin
      v = 16'($urandom);
      conv(v);
      chk("dma_addr_inc", 32'(dma_addr_inc), 32'(i == 31));
    end
    @(posedge aclk);
    #1 chk("dma_addr", 32'(dma_addr), 32'h1);
    chk("fixed channel", 32'(scan_channel), 32'h7);
    rd(8'h10);
    chk("dma status", 32'(d[1:0]), 32'h3);
    rd(8'h40);
    chk("first slot", 32'(d[15:0]), 32'(v));
    rd(8'h44);
    chk("second slot", 32'(d[15:0]), 32'(slots[1]));
    finish_test;
  end
endmodule
